/* adct_consts.vh */
// constants for the converter conversion timing block
// assumes one clock of one cpu period (two half periods) per edge
`ifndef ADCT_CONSTS_VH
`define ADCT_CONSTS_VH
`define ADCT_CLK_PERIOD_NS     100
`define ADCT_HALF_PER_CLK      2
`define ADCT_CC_SEL_FAST       2'h0
`define ADCT_CC_SEL_RSVD       2'h1
`define ADCT_CC_SEL_SLOW       2'h2
`define ADCT_CC_SEL_MID        2'h3
`define ADCT_CC_HALF_FAST      24
`define ADCT_CC_HALF_SLOW      96
`define ADCT_CC_HALF_MID       48
`define ADCT_SAMPLE_PERIODS    2
`define ADCT_CONV_PERIODS      14
`define ADCT_TAIL_HALF         4
`define ADCT_RESULT_MAX        10'h3FF
`define ADCT_RESULT_MIN        10'h000
`endif

/* adct_tick.v */
// conversion clock tick generator
// assumes the select is held stable during a conversion
`timescale 1ns/10ps
`default_nettype none
`include "adct_consts.vh"
module adct_tick
(
    input  wire       sys_clk_in,
    input  wire       rst_b_in,
    input  wire       run_in,
    input  wire [1:0] conv_clock_select_in,
    output reg        tick_out
);
    // conversion clock lengths in whole cpu clocks, cut to the counter width on purpose
    localparam integer FAST_I = `ADCT_CC_HALF_FAST / `ADCT_HALF_PER_CLK;
    localparam integer SLOW_I = `ADCT_CC_HALF_SLOW / `ADCT_HALF_PER_CLK;
    localparam integer MID_I  = `ADCT_CC_HALF_MID / `ADCT_HALF_PER_CLK;

    // conversion clock length in cpu clocks for a select code
    function [6:0] cc_clocks;
        input [1:0] sel;
        begin
            case (sel)
                `ADCT_CC_SEL_SLOW: cc_clocks = SLOW_I[6:0];
                `ADCT_CC_SEL_MID:  cc_clocks = MID_I[6:0];
                default:           cc_clocks = FAST_I[6:0];
            endcase
        end
    endfunction

    reg [6:0] count;

    // count parked at one while idle: the tick is registered, so starting at zero
    // would land every tick one clock after its period edge
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count    <= 7'h00;
            tick_out <= 1'b0;
        end
        else if (!run_in)
        begin
            count    <= 7'h01;
            tick_out <= 1'b0;
        end
        else if (count == cc_clocks(conv_clock_select_in) - 7'h01)
        begin
            count    <= 7'h00;
            tick_out <= 1'b1;
        end
        else
        begin
            count    <= count + 7'h01;
            tick_out <= 1'b0;
        end
    end
endmodule // adct_tick
`default_nettype wire

/* adct_timing.v */
// conversion sequencer: sample phase, conversion, result load
// assumes synchronous inputs and a comparator that reports each bit decision
// Notes on behaviour
// - the conversion clock is 24, 96 or 48 half cpu periods for select 00, 10, 11.
// - the sample clock is one, two, four or eight conversion clocks for select 00 to 11.
// - sampling lasts exactly two sample clocks and later input changes are ignored.
// - a conversion takes fourteen conversion clocks plus the sample time plus four half periods.
// - sample and conversion durations are fixed by the sequencer, not upper bounds.
// - inputs below ground or above reference give a result of 000 or 3FF.
// - one half cpu period is one time unit and only the rising clock edge acts.
`timescale 1ns/10ps
`default_nettype none
`include "adct_consts.vh"
module adct_timing
(
    input  wire       sys_clk_in,
    input  wire       rst_b_in,
    input  wire       start_in,
    input  wire [1:0] conv_clock_select_in,
    input  wire [1:0] sample_clock_select_in,
    input  wire       cmp_high_in,
    input  wire       under_range_in,
    input  wire       over_range_in,
    output reg        sample_out,
    output reg        busy_out,
    output reg        done_out,
    output reg        bad_select_out,
    output reg  [9:0] trial_out,
    output reg  [9:0] result_out
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONV   = 2'h2;
    localparam ST_TAIL   = 2'h3;
    // four half periods is two cpu clocks at one clock per two units
    localparam integer TAIL_CLKS_I = `ADCT_TAIL_HALF / `ADCT_HALF_PER_CLK;
    localparam integer SAMPLE_I    = `ADCT_SAMPLE_PERIODS;
    localparam integer CONV_I      = `ADCT_CONV_PERIODS;
    // last count values, cut to the counter widths on purpose
    localparam [1:0]   TAIL_LAST   = TAIL_CLKS_I[1:0] - 2'h1;
    localparam [4:0]   CONV_LAST   = CONV_I[4:0] - 5'h01;
    localparam [3:0]   BITS_LAST   = 4'h9;   // ten decisions counted from zero

    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] cc_sel;      // selects latched at start so timing is fixed
    reg [1:0] sc_sel;
    reg [4:0] ticks;
    reg [1:0] tail_cnt;
    reg       range_lo;
    reg       range_hi;
    reg [9:0] sar;
    wire      tick;
    wire      run;         // tick generator runs through sampling and conversion
    wire      decide;      // one bit decision on this clock
    wire      load;        // last tail clock, result register loads
    wire [9:0] decide_mask;
    wire [9:0] next_sar;

    // sample phase length in conversion clocks for a sample select code
    function [4:0] sample_ticks;
        input [1:0] sel;
        begin
            sample_ticks = SAMPLE_I[4:0] << sel;
        end
    endfunction

    // one-hot trial bit for a decision step; steps ten to fifteen give no bit
    function [9:0] bit_mask;
        input [4:0] step;
        begin
            bit_mask = 10'h200 >> step[3:0];
        end
    endfunction

    // the conversion clock runs only while sampling or converting
    assign run = (state == ST_SAMPLE) || (state == ST_CONV);

    adct_tick u_tick
    (
        .sys_clk_in           (sys_clk_in),
        .rst_b_in             (rst_b_in),
        .run_in               (run),
        .conv_clock_select_in (cc_sel),
        .tick_out             (tick)
    );

    // state transitions; durations counted, never cut short
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:   if (start_in) next_state = ST_SAMPLE;
            ST_SAMPLE: if (tick && ticks == sample_ticks(sc_sel) - 5'h01)
                           next_state = ST_CONV;
            ST_CONV:   if (tick && ticks == CONV_LAST)
                           next_state = ST_TAIL;
            ST_TAIL:   if (tail_cnt == TAIL_LAST) next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // decision strobe on the first ten of fourteen conversion clocks, and the load cycle
    assign decide      = (state == ST_CONV) && tick && (ticks <= {1'b0, BITS_LAST});
    assign decide_mask = decide ? bit_mask(ticks) : 10'h000;
    assign load        = (state == ST_TAIL) && (next_state == ST_IDLE);

    // state register; only rising edges used, so one clock is two time units
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // conversion clocks within a phase, cleared on every phase change
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            ticks <= 5'h00;
        else if (state != next_state)
            ticks <= 5'h00;
        else if (tick)
            ticks <= ticks + 5'h01;
    end

    // tail clocks between the last conversion clock and the result load
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            tail_cnt <= 2'h0;
        else if (state == ST_TAIL)
            tail_cnt <= tail_cnt + 2'h1;
        else
            tail_cnt <= 2'h0;
    end

    // selects latched at start so the timing cannot move under a running conversion
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cc_sel         <= `ADCT_CC_SEL_FAST;
            sc_sel         <= 2'h0;
            bad_select_out <= 1'b0;
        end
        else if (state == ST_IDLE && start_in)
        begin
            cc_sel         <= conv_clock_select_in;
            sc_sel         <= sample_clock_select_in;
            // reserved code is flagged and falls back to the fastest timing
            bad_select_out <= (conv_clock_select_in == `ADCT_CC_SEL_RSVD);
        end
    end

    // range caught on the last sampling edge; later input moves are ignored
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            range_lo <= 1'b0;
            range_hi <= 1'b0;
        end
        else if (state == ST_SAMPLE && next_state == ST_CONV)
        begin
            range_lo <= under_range_in;
            range_hi <= over_range_in;
        end
    end

    // next decision word; each bit takes the comparator once, msb first
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1)
        begin : g_bit
            assign next_sar[gi] = decide_mask[gi] ? cmp_high_in : sar[gi];
        end
    endgenerate

    // decision register, cleared at start so no bit of the last result survives
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sar <= 10'h000;
        else if (state == ST_IDLE && start_in)
            sar <= 10'h000;
        else
            sar <= next_sar;
    end

    // trial word: keep decided bits, set the one under test, offer the next
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            trial_out <= 10'h000;
        else if (state == ST_IDLE && start_in)
            trial_out <= 10'h200;
        else if (decide)
            trial_out <= (trial_out & ~bit_mask(ticks))
                       | (cmp_high_in ? bit_mask(ticks) : 10'h000)
                       | bit_mask(ticks + 5'h01);
    end

    // status outputs registered from the next state so they line up with it
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sample_out <= 1'b0;
            busy_out   <= 1'b0;
            done_out   <= 1'b0;
        end
        else
        begin
            sample_out <= (next_state == ST_SAMPLE);
            busy_out   <= (next_state != ST_IDLE);
            done_out   <= load;
        end
    end

    // result loaded once per conversion; range flags win over the decisions
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            result_out <= 10'h000;
        else if (load)
        begin
            if (range_lo)
                result_out <= `ADCT_RESULT_MIN;
            else if (range_hi)
                result_out <= `ADCT_RESULT_MAX;
            else
                result_out <= sar;
        end
    end
endmodule // adct_timing
`default_nettype wire

/* adct_monitor.sv */
// port checker for the conversion sequencer
// bound to every adct_timing instance
`timescale 1ns/10ps
`default_nettype none
module adct_monitor
(
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire logic       start_in,
    input wire logic [1:0] conv_clock_select_in,
    input wire logic       under_range_in,
    input wire logic       over_range_in,
    input wire logic       sample_out,
    input wire logic       busy_out,
    input wire logic       done_out,
    input wire logic       bad_select_out,
    input wire logic [9:0] result_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // a start counts whenever the sequencer is idle, the load cycle excluded
    wire go = start_in && !busy_out;
    AST_TAKE: assert property (go |=> busy_out && sample_out) else $error("start lost");
    AST_RSVD: assert property (go |=>
        bad_select_out == ($past(conv_clock_select_in) == 2'h1)) else $error("select flag");
    AST_SMIN: assert property ($rose(sample_out) |-> sample_out[*8]) else $error("short");
    AST_SBSY: assert property (sample_out |-> busy_out) else $error("sample idle");
    AST_TAIL: assert property ($fell(sample_out) |-> !done_out[*8]) else $error("no conv");
    AST_END: assert property (done_out |-> !busy_out && !sample_out) else $error("end");
    AST_LOW: assert property (done_out && under_range_in |->
        result_out == 10'h000) else $error("low clamp");
    AST_HIGH: assert property (done_out && over_range_in && !under_range_in |->
        result_out == 10'h3FF) else $error("high clamp");
    AST_HOLD: assert property (!done_out |-> $stable(result_out)) else $error("drift");
    C_OVR: cover property (done_out && over_range_in);
    C_UND: cover property (done_out && under_range_in);
    C_RSV: cover property (go && conv_clock_select_in == 2'h1);
endmodule // adct_monitor
bind adct_timing adct_monitor u_mon (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .start_in(start_in), .conv_clock_select_in(conv_clock_select_in),
    .under_range_in(under_range_in), .over_range_in(over_range_in), .sample_out(sample_out),
    .busy_out(busy_out), .done_out(done_out), .bad_select_out(bad_select_out),
    .result_out(result_out));
`default_nettype wire

/* adct_analog_model.sv */
// sample-and-hold and comparator facing the sequencer
// assumes trial words settle well before each decision edge
`timescale 1ns/10ps
`default_nettype none
module adct_analog_model
(
    input  wire logic               sys_clk_in,
    input  wire logic               sample_in,
    input  wire logic        [9:0]  trial_in,
    input  wire logic signed [11:0] ain_in,
    output logic                    cmp_high_out,
    output logic                    under_out,
    output logic                    over_out
);
    logic signed [11:0] held = 12'sh000;
    // frozen after sampling, so later input moves cannot leak in
    always @(posedge sys_clk_in)
    begin
        if (sample_in)
            held <= ain_in;
    end
    assign cmp_high_out = held >= $signed({2'h0, trial_in});
    assign under_out    = held < 0;
    assign over_out     = held > 12'sh3FF;
endmodule // adct_analog_model
`default_nettype wire

/* adct_timing_tb.sv */
// self-checking bench for the conversion sequencer
// assumes the analog model answers trial words at once
`timescale 1ns/10ps
`default_nettype none
module adct_timing_tb;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               start = 1'b0;
    logic [1:0]         cc = 2'h0;
    logic [1:0]         ss = 2'h0;
    logic signed [11:0] ain = 12'sh000;
    logic               cmp, und, ovr, smp_o, busy, done, bad;
    logic [9:0]         trial, result;
    logic [9:0]         exp_q[$];
    int                 num_errors = 0;
    int                 num_checks = 0;
    initial forever #50 clk = ~clk;
    adct_timing uut (.sys_clk_in(clk), .rst_b_in(rst_b), .start_in(start),
        .conv_clock_select_in(cc), .sample_clock_select_in(ss), .cmp_high_in(cmp),
        .under_range_in(und), .over_range_in(ovr), .sample_out(smp_o), .busy_out(busy),
        .done_out(done), .bad_select_out(bad), .trial_out(trial), .result_out(result));
    adct_analog_model u_ana (.sys_clk_in(clk), .sample_in(smp_o), .trial_in(trial),
        .ain_in(ain), .cmp_high_out(cmp), .under_out(und), .over_out(ovr));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        num_checks++;
        if (seen !== ex)
        begin
            num_errors++;
            $display("[ERR] %s exp %0h seen %0h", nm, ex, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // each load is matched against the oldest noted result
    always @(negedge clk)
    begin
        if (done === 1'b1)
            check("result", {22'h0, result}, {22'h0, exp_q.pop_front()});
    end
    // one conversion; the input wanders once sampling is over
    task automatic conv(input logic [1:0] c, input logic [1:0] s, input logic signed [11:0] a);
        int ncc, smp, tot, nb, ns;
        ncc = (c == 2'h2) ? 48 : (c == 2'h3) ? 24 : 12;
        smp = 2 * ncc * (1 << s);
        tot = smp + 14 * ncc + 2;
        nb = 0;
        ns = 0;
        exp_q.push_back(a < 0 ? 10'h000 : a > 12'sh3FF ? 10'h3FF : a[9:0]);
        cc = c;
        ss = s;
        ain = a;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check("bad_select", {31'h0, bad}, {31'h0, c == 2'h1});
        while (done !== 1'b1 && nb < 3000)
        begin
            nb += busy;
            ns += smp_o;
            if (smp_o === 1'b0)
                ain = 12'($urandom);
            @(negedge clk);
        end
        check("sample_len", ns, smp);
        check("conv_len", nb, tot);
    endtask
    initial
    begin
        void'($urandom(14507));
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        // software never sends the reserved code; a legal one stands in for it
        for (int i = 0; i < 16; i++)
            conv(i[3:2] == 2'h1 ? 2'h3 : i[3:2], i[1:0], i == 0 ? -12'sd5
                : i == 1 ? 12'sd1100 : i == 2 ? 12'sd1023
                : i == 3 ? 12'sd0 : 12'($urandom_range(1023)));
        // one deliberate misuse checks the flag and the fallback timing
        conv(2'h1, 2'h0, 12'($urandom_range(1023)));
        @(negedge clk);
        check("pending", exp_q.size(), 0);
        final_report();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule // adct_timing_tb
`default_nettype wire
